// ==== dv/afs_file_model.sv ====
/*
  File table and file memory beside the interpreter. Assumes lookups are
  answered combinationally and memory bytes in the cycle of the read pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module afs_file_model (
  // Clock
  input  wire logic                        i_clk,
  // File table
  input  wire afs_pkg::afs_lookup_req_type i_req,
  output afs_pkg::afs_lookup_rsp_type      o_rsp,
  // File memory
  input  wire logic                        i_rd,
  input  wire afs_pkg::afs_mem_req_type    i_mem,
  output logic [7:0]                       o_data
);
  import afs_pkg::*;

  logic [15:0] fid;
  logic [7:0]  last_q;

  // Short identifier n names file 0100 + n
  always_comb begin
    fid = i_req.by_sfi ? {11'h008, i_req.sfi} : i_req.fid;
    o_rsp = '0;
    o_rsp.fid = fid;
    case (fid)
      16'h0101: o_rsp = {1'b1, 1'b1, fid, 24'h000010};
      16'h0102: o_rsp = {1'b1, 1'b1, fid, 24'h008010};
      16'h2F00: o_rsp = {1'b1, 1'b0, fid, 24'h000004};
      default:  o_rsp.hit = 1'b0;
    endcase
  end

  // Outside the pulse the bus shows no stale byte
  assign o_data = i_rd ? (i_mem.fid[7:0] ^ i_mem.offset[7:0]) : ~last_q;

  always_ff @(posedge i_clk) begin
    if (i_rd) last_q <= o_data;
  end
endmodule : afs_file_model

`default_nettype wire

// ==== dv/afs_top_sva.sv ====
/*
  Checker for the command interpreter top: protocol relations on the
  command, response and file memory ports. Assumes it is bound to afs_top
  and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none

module afs_top_sva (
  // Clock and reset
  input wire logic                        i_clk,
  input wire logic                        i_sys_rst,
  // Command and response streams
  input wire logic                        i_cmd_valid,
  input wire afs_pkg::afs_byte_type       i_cmd,
  input wire logic                        o_cmd_ready,
  input wire logic                        o_rsp_valid,
  input wire afs_pkg::afs_byte_type       o_rsp,
  input wire logic                        i_rsp_ready,
  // File table and memory
  input wire afs_pkg::afs_lookup_req_type o_lookup,
  input wire afs_pkg::afs_lookup_rsp_type i_lookup,
  input wire logic                        o_mem_rd,
  input wire afs_pkg::afs_mem_req_type    o_mem,
  input wire logic [7:0]                  i_mem_data,
  // Status
  input wire logic                        o_ext_len_support,
  input wire logic                        o_app_selected
);
  import afs_pkg::*;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  chk_ext_len_flag: assert property (
    o_ext_len_support) else $error("extended length flag low");
  chk_last_answered: assert property (
    i_cmd_valid && o_cmd_ready && i_cmd.last
    |=> !o_cmd_ready ##[1:600] o_rsp_valid)
    else $error("command not answered in time");
  chk_rsp_held: assert property (
    o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp))
    else $error("response byte changed before taken");
  chk_mem_single: assert property (
    o_mem_rd |=> !o_mem_rd) else $error("memory read longer than a pulse");
  chk_offset_step: assert property (
    o_mem_rd ##2 o_mem_rd
    |-> o_mem.offset == $past(o_mem.offset, 2) + 24'h1)
    else $error("read offset did not advance by one");
  chk_idle_no_mem: assert property (
    o_cmd_ready |-> !o_mem_rd) else $error("memory read while idle");
  chk_ready_after_sw: assert property (
    $rose(o_cmd_ready) |-> $past(o_rsp_valid))
    else $error("ready returned before status pushed");
  chk_app_in_cmd: assert property (
    $rose(o_app_selected) |-> !o_cmd_ready)
    else $error("application selected outside a command");
endmodule : afs_top_sva

bind afs_top afs_top_sva afs_top_sva_i (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cmd_valid(i_cmd_valid),
  .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid),
  .o_rsp(o_rsp), .i_rsp_ready(i_rsp_ready), .o_lookup(o_lookup),
  .i_lookup(i_lookup), .o_mem_rd(o_mem_rd), .o_mem(o_mem),
  .i_mem_data(i_mem_data), .o_ext_len_support(o_ext_len_support),
  .o_app_selected(o_app_selected)
);

`default_nettype wire

// ==== dv/afs_top_tb_top.sv ====
/*
  Self-checking bench for the command interpreter. Assumes the file model
  stands on the table and memory ports; the bench plays the terminal.
*/
`timescale 1ns/1ps
`default_nettype none

module afs_top_tb_top;
  import afs_pkg::*;
  typedef logic [7:0] afs_q_type[$];

  logic               i_clk       = 1'b0;
  logic               i_sys_rst   = 1'b1;
  logic               i_cmd_valid = 1'b0;
  afs_byte_type       i_cmd       = '0;
  logic               i_rsp_ready = 1'b0;
  logic               o_cmd_ready;
  logic               o_rsp_valid;
  afs_byte_type       o_rsp;
  afs_lookup_req_type o_lookup;
  afs_lookup_rsp_type i_lookup;
  logic               o_mem_rd;
  afs_mem_req_type    o_mem;
  logic [7:0]         i_mem_data;
  logic               o_ext_len_support;
  logic               o_app_selected;
  int                 failures    = 0;
  int                 num_checks  = 0;
  int                 stall       = 0;

  always #20 i_clk = ~i_clk;

  afs_top afs_top_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid),
    .o_rsp(o_rsp), .i_rsp_ready(i_rsp_ready), .o_lookup(o_lookup),
    .i_lookup(i_lookup), .o_mem_rd(o_mem_rd), .o_mem(o_mem),
    .i_mem_data(i_mem_data), .o_ext_len_support(o_ext_len_support),
    .o_app_selected(o_app_selected)
  );

  afs_file_model afs_file_model_i (
    .i_clk(i_clk), .i_req(o_lookup), .o_rsp(i_lookup),
    .i_rd(o_mem_rd), .i_mem(o_mem), .o_data(i_mem_data)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  // Expected bytes: model byte is fid low ^ offset low, then status
  function automatic afs_q_type rsp(input logic [7:0] f, input int off,
                                    input int cnt, input logic [15:0] sw);
    afs_q_type q;
    for (int i = 0; i < cnt; i++) q.push_back(f ^ 8'(off + i));
    q.push_back(sw[15:8]);
    q.push_back(sw[7:0]);
    return q;
  endfunction : rsp

  // Bytes change at the falling edge; ready never drops mid-command
  task automatic run(input afs_q_type cmd, input afs_q_type exp);
    afs_q_type got;
    int n;
    foreach (cmd[k]) begin
      @(negedge i_clk);
      i_cmd_valid = 1'b1;
      i_cmd = {k == cmd.size() - 1, cmd[k]};
      n = 0;
      while (!o_cmd_ready && n < 50) begin
        @(negedge i_clk);
        n++;
      end
    end
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
    i_cmd = '0;
    for (n = 0; n < 2000; n++) begin
      @(negedge i_clk);
      i_rsp_ready = (n >= stall);
      if (i_rsp_ready && o_rsp_valid) begin
        got.push_back(o_rsp.data);
        if (o_rsp.last) break;
      end
    end
    @(negedge i_clk);
    i_rsp_ready = 1'b0;
    check(got.size(), exp.size());
    foreach (got[k]) if (k < exp.size()) check(got[k], exp[k]);
  endtask : run

  task automatic do_reset();
    i_sys_rst = 1'b1;
    repeat (3) @(negedge i_clk);
    i_sys_rst = 1'b0;
  endtask : do_reset

  task automatic t_root();
    run('{8'h00, 8'hA4, 8'h00, 8'h0C}, rsp(0, 0, 0, SW_OK));
    run('{8'h0C, 8'hA4, 8'h00, 8'h0C}, rsp(0, 0, 0, SW_BAD_CLA));
    check(o_app_selected, 0);
    $display("test root done");
  endtask : t_root

  task automatic t_app();
    run('{8'h00, 8'hA4, 8'h02, 8'h0C, 8'h02, 8'h01, 8'h01},
        rsp(0, 0, 0, SW_NOT_FOUND));
    run('{8'h00, 8'hA4, 8'h04, 8'h0C, 8'h07, 8'h11, 8'h22, 8'h33, 8'h44,
          8'h55, 8'h66, 8'h78}, rsp(0, 0, 0, SW_NOT_FOUND));
    run('{8'h00, 8'hA4, 8'h04, 8'h0C, 8'h07, 8'h11, 8'h22, 8'h33, 8'h44,
          8'h55, 8'h66, 8'h77}, rsp(0, 0, 0, SW_OK));
    check(o_app_selected, 1);
    $display("test application done");
  endtask : t_app

  task automatic t_file();
    run('{8'h0C, 8'hA4, 8'h02, 8'h0C, 8'h01, 8'h01},
        rsp(0, 0, 0, SW_WRONG_LEN));
    run('{8'h0C, 8'hA4, 8'h02, 8'h0C, 8'h02, 8'h01, 8'h01},
        rsp(0, 0, 0, SW_OK));
    run('{8'h00, 8'hB0, 8'h00, 8'h02, 8'h04}, rsp(8'h01, 2, 4, SW_OK));
    run('{8'h00, 8'hA4, 8'h04, 8'h0C, 8'h07, 8'h11, 8'h22, 8'h33, 8'h44,
          8'h55, 8'h66, 8'h77}, rsp(0, 0, 0, SW_OK));
    run('{8'h00, 8'hB0, 8'h00, 8'h00, 8'h01},
        rsp(0, 0, 0, SW_NO_CUR_EF));
    $display("test file done");
  endtask : t_file

  task automatic t_sfi();
    stall = 30;
    run('{8'h00, 8'hB0, 8'h81, 8'h03, 8'h00}, rsp(8'h01, 3, 13, SW_OK));
    stall = 0;
    run('{8'h0C, 8'hB0, 8'h81, 8'h11, 8'h01},
        rsp(0, 0, 0, SW_BAD_OFFSET));
    run('{8'h0C, 8'hB0, 8'h81, 8'h10, 8'h01}, rsp(0, 0, 0, SW_OK));
    run('{8'h00, 8'hB0, 8'h81, 8'h0E, 8'h00, 8'h00, 8'h02},
        rsp(8'h01, 14, 2, SW_OK));
    $display("test short identifier done");
  endtask : t_sfi

  task automatic t_odd();
    run('{8'h00, 8'hB1, 8'h01, 8'h02, 8'h04, 8'h54, 8'h02, 8'h80, 8'h00,
          8'h03}, rsp(8'h02, 'h8000, 3, SW_OK));
    run('{8'h00, 8'hB1, 8'h00, 8'h00, 8'h05, 8'h54, 8'h03, 8'h00, 8'h80,
          8'h01, 8'h01}, rsp(8'h02, 'h8001, 1, SW_OK));
    run('{8'h0C, 8'hB1, 8'h00, 8'h02, 8'h03, 8'h54, 8'h01, 8'h05, 8'h02},
        rsp(8'h02, 5, 2, SW_OK));
    run('{8'h00, 8'hB1, 8'h01, 8'h02, 8'h04, 8'h53, 8'h02, 8'h80, 8'h00,
          8'h03}, rsp(0, 0, 0, SW_BAD_DATA));
    $display("test large offset done");
  endtask : t_odd

  task automatic t_refuse();
    do_reset();
    check(o_app_selected, 0);
    run('{8'h10, 8'hA4, 8'h00, 8'h0C}, rsp(0, 0, 0, SW_NO_CHAIN));
    run('{8'h80, 8'hA4, 8'h00, 8'h0C}, rsp(0, 0, 0, SW_BAD_CLA));
    run('{8'h00, 8'hCA, 8'h00, 8'h0C}, rsp(0, 0, 0, SW_BAD_INS));
    run('{8'h00, 8'hB0, 8'hA1, 8'h00, 8'h01},
        rsp(0, 0, 0, SW_BAD_P1P2));
    run('{8'h00, 8'hA4, 8'h00}, rsp(0, 0, 0, SW_WRONG_LEN));
    $display("test refusals done");
  endtask : t_refuse

  // Whole run is a few hundred cycles; the limit of 20000 cycles leaves ample margin
  initial begin
    #(40 * 20000);
    failures++;
    summarize();
  end

  initial begin
    do_reset();
    t_root();
    t_app();
    t_file();
    check(o_ext_len_support, 1);
    t_sfi();
    t_odd();
    t_refuse();
    summarize();
  end
endmodule : afs_top_tb_top

`default_nettype wire

// ==== src/afs_pkg.sv ====
/*
  Shared constants and carrier types for the command interpreter that
  selects files and reads transparent files. Assumes the byte stream of
  one command unit arrives framed by a last flag from the transport layer.
*/
package afs_pkg;

  // Command header values
  localparam logic [7:0] CLA_PLAIN       = 8'h00;
  localparam logic [7:0] CLA_SECURE      = 8'h0C;
  localparam int         CLA_CHAIN_BIT   = 4;
  localparam logic [7:0] INS_SELECT      = 8'hA4;
  localparam logic [7:0] INS_READ_EVEN   = 8'hB0;
  localparam logic [7:0] INS_READ_ODD    = 8'hB1;
  localparam logic [7:0] P1_SEL_ROOT     = 8'h00;
  localparam logic [7:0] P1_SEL_APP      = 8'h04;
  localparam logic [7:0] P1_SEL_EF       = 8'h02;
  localparam logic [7:0] P2_NO_RSP_DATA  = 8'h0C;
  localparam logic [15:0] EF_ID_LEN      = 16'h0002;
  localparam int         P1_SFI_FLAG_BIT = 7;
  localparam logic [7:0] TAG_OFFSET      = 8'h54;
  localparam logic [7:0] OFFSET_LEN_MAX  = 8'h03;
  localparam logic [16:0] NE_SHORT_ZERO  = 17'h00100;
  localparam logic [16:0] NE_EXT_ZERO    = 17'h10000;

  // Sizes
  localparam int BODY_MAX    = 32;
  localparam int BODY_AW     = 5;
  localparam int AID_MAX     = 16;
  localparam int RSP_DEPTH   = 4;
  localparam int OFFSET_W    = 24;

  // Status words
  localparam logic [15:0] SW_OK          = 16'h9000;
  localparam logic [15:0] SW_WRONG_LEN   = 16'h6700;
  localparam logic [15:0] SW_NO_CHAIN    = 16'h6884;
  localparam logic [15:0] SW_NO_CUR_EF   = 16'h6986;
  localparam logic [15:0] SW_BAD_DATA    = 16'h6A80;
  localparam logic [15:0] SW_NOT_FOUND   = 16'h6A82;
  localparam logic [15:0] SW_BAD_P1P2    = 16'h6A86;
  localparam logic [15:0] SW_BAD_OFFSET  = 16'h6B00;
  localparam logic [15:0] SW_BAD_INS     = 16'h6D00;
  localparam logic [15:0] SW_BAD_CLA     = 16'h6E00;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } afs_byte_type;

  typedef struct packed {
    logic        by_sfi;
    logic [4:0]  sfi;
    logic [15:0] fid;
  } afs_lookup_req_type;

  typedef struct packed {
    logic                hit;
    logic                in_app;
    logic [15:0]         fid;
    logic [OFFSET_W-1:0] size;
  } afs_lookup_rsp_type;

  typedef struct packed {
    logic [15:0]         fid;
    logic [OFFSET_W-1:0] offset;
  } afs_mem_req_type;

  typedef enum logic [2:0] {
    ST_RX, ST_EXEC, ST_LOOK, ST_READ, ST_PUSH, ST_SW1, ST_SW2
  } afs_state_type;

endpackage : afs_pkg

// ==== src/afs_top.sv ====
/*
  Command interpreter: select root file, application directory and
  elementary file, and read transparent files (even and odd INS), with a
  response FIFO. Assumes a byte-wide command stream framed by i_cmd.last,
  an external file table answering lookups combinationally and a file
  memory answering reads in the cycle its request is high.
*/
// Functional notes
// - Root select CLA 00 A4 00 0C, no body, answers status only.
// - Application select CLA 00 A4 04 0C, Lc and name, no Le.
// - Application files reachable only after name select; name select works anywhere.
// - File select CLA 00/0C A4 02 0C, Lc 02, two-byte id, no data.
// - Device supports short identifier access; terminal should prefer it.
// - Even read of selected file, P1P2 offset, Le present, returns data.
// - Even read by short identifier, offset in P2, up to Le bytes.
// - Extended length fields accepted and advertised.
// - Chaining only for general authenticate; refused here.
// - Offsets above 32 767 need the odd read format.
// - Odd read B1, P1P2 name file, data holds tag-54 offset, Le.
// - Status 9000 on success, other status on any failure.
// - Device implements the odd read variant for large files.
`timescale 1ns/1ps
`default_nettype none

module afs_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : afs_fifo

module afs_top #(
  // Application name; arbitrary default
  parameter int                    AID_LEN   = 7,
  parameter logic [afs_pkg::AID_MAX*8-1:0] AID_VALUE = {
    8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, {9{8'h00}}}
) (
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_sys_rst,
  // Command byte stream
  input  wire logic                        i_cmd_valid,
  input  wire afs_pkg::afs_byte_type       i_cmd,
  output logic                             o_cmd_ready,
  // Response byte stream
  output logic                             o_rsp_valid,
  output afs_pkg::afs_byte_type            o_rsp,
  input  wire logic                        i_rsp_ready,
  // File table lookup
  output afs_pkg::afs_lookup_req_type      o_lookup,
  input  wire afs_pkg::afs_lookup_rsp_type i_lookup,
  // File memory
  output logic                             o_mem_rd,
  output afs_pkg::afs_mem_req_type         o_mem,
  input  wire logic [7:0]                  i_mem_data,
  // Status
  output logic                             o_ext_len_support,
  output logic                             o_app_selected
);
  import afs_pkg::*;

  typedef enum logic {ACT_SELECT, ACT_READ} afs_act_type;

  afs_state_type       state;
  afs_act_type         act;
  logic [7:0]          hdr [4];
  logic [2:0]          hdr_n;
  logic [7:0]          body [BODY_MAX];
  logic [5:0]          body_n;
  logic                body_ovf;
  logic                app_sel;
  logic                ef_valid;
  logic [15:0]         ef_fid;
  logic [OFFSET_W-1:0] ef_size;
  logic [OFFSET_W-1:0] rd_off;
  logic [16:0]         rd_ne;
  logic [16:0]         rd_cnt;
  logic [15:0]         sw;

  // Decoded body fields
  logic                has_lc;
  logic                has_le;
  logic                len_ok;
  logic [15:0]         lc;
  logic [16:0]         ne;
  logic [BODY_AW-1:0]  ds;
  logic                aid_match;
  logic                tlv_ok;
  logic [OFFSET_W-1:0] tlv_off;
  logic [OFFSET_W-1:0] remain;

  // FIFO fill side
  logic                push_valid;
  afs_byte_type        push_data;
  logic                push_ready;

  function automatic logic [7:0] body_at(input logic [BODY_AW-1:0] idx);
    body_at = body[idx];
  endfunction : body_at

  function automatic logic [16:0] min_ne(input logic [16:0] a,
                                         input logic [OFFSET_W-1:0] b);
    min_ne = ({7'h00, a} < b) ? a : b[16:0];
  endfunction : min_ne

  assign o_cmd_ready       = (state == ST_RX);
  assign o_ext_len_support = 1'b1;
  assign o_app_selected    = app_sel;
  assign remain            = i_lookup.size - rd_off;

  // Length field decode, short and extended forms
  always_comb begin
    has_lc = 1'b0;
    has_le = 1'b0;
    len_ok = !body_ovf;
    lc     = '0;
    ne     = '0;
    ds     = '0;
    if (body_n == 6'h00) begin
      len_ok = !body_ovf;
    end else if (body_n == 6'h01) begin
      has_le = 1'b1;
      ne     = (body[0] == 8'h00) ? NE_SHORT_ZERO : {9'h000, body[0]};
    end else if (body[0] != 8'h00) begin
      has_lc = 1'b1;
      lc     = {8'h00, body[0]};
      ds     = BODY_AW'(1);
      if (16'(body_n) == lc + 16'h0002) begin
        has_le = 1'b1;
        ne     = (body_at(BODY_AW'(body_n - 1'b1)) == 8'h00) ? NE_SHORT_ZERO
               : {9'h000, body_at(BODY_AW'(body_n - 1'b1))};
      end else if (16'(body_n) != lc + 16'h0001) begin
        len_ok = 1'b0;
      end
    end else if (body_n == 6'h03) begin
      has_le = 1'b1;
      ne     = ({body[1], body[2]} == 16'h0000) ? NE_EXT_ZERO
             : {1'b0, body[1], body[2]};
    end else if (body_n == 6'h02) begin
      // Cut extended length field; its third byte is stale
      len_ok = 1'b0;
    end else begin
      has_lc = 1'b1;
      lc     = {body[1], body[2]};
      ds     = BODY_AW'(3);
      if (16'(body_n) == lc + 16'h0005) begin
        has_le = 1'b1;
        ne     = ({body_at(BODY_AW'(body_n - 6'h02)),
                   body_at(BODY_AW'(body_n - 1'b1))} == 16'h0000)
               ? NE_EXT_ZERO
               : {1'b0, body_at(BODY_AW'(body_n - 6'h02)),
                  body_at(BODY_AW'(body_n - 1'b1))};
      end else if (16'(body_n) != lc + 16'h0003) begin
        len_ok = 1'b0;
      end
    end
  end

  // Name compare and offset object decode
  always_comb begin
    logic [7:0] olen;
    olen      = body_at(BODY_AW'(ds + 1'b1));
    aid_match = (lc == 16'(AID_LEN));
    for (int i = 0; i < AID_MAX; i++) begin
      if (i < AID_LEN && body_at(BODY_AW'(32'(ds) + i))
          != AID_VALUE[(AID_MAX-1-i)*8 +: 8]) begin
        aid_match = 1'b0;
      end
    end
    tlv_ok  = (body_at(ds) == TAG_OFFSET) && (olen != 8'h00)
           && (olen <= OFFSET_LEN_MAX) && (lc == {8'h00, olen} + 16'h0002);
    tlv_off = '0;
    for (int i = 0; i < 3; i++) begin
      if (i < 32'(olen)) begin
        tlv_off = {tlv_off[OFFSET_W-9:0],
                   body_at(BODY_AW'(32'(ds) + 2 + i))};
      end
    end
  end

  // Command byte capture
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      hdr_n    <= '0;
      body_n   <= '0;
      body_ovf <= 1'b0;
    end else if (state == ST_RX && i_cmd_valid) begin
      if (hdr_n != 3'h4) begin
        hdr[hdr_n[1:0]] <= i_cmd.data;
        hdr_n           <= hdr_n + 1'b1;
      end else if (body_n == 6'(BODY_MAX)) begin
        body_ovf <= 1'b1;
      end else begin
        body[body_n[BODY_AW-1:0]] <= i_cmd.data;
        body_n                    <= body_n + 1'b1;
      end
    end else if (state == ST_SW2 && push_ready) begin
      hdr_n    <= '0;
      body_n   <= '0;
      body_ovf <= 1'b0;
    end
  end

  // Main sequence
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state    <= ST_RX;
      act      <= ACT_SELECT;
      sw       <= SW_OK;
      app_sel  <= 1'b0;
      ef_valid <= 1'b0;
      ef_fid   <= '0;
      ef_size  <= '0;
      rd_off   <= '0;
      rd_ne    <= '0;
      rd_cnt   <= '0;
      o_lookup <= '0;
      o_mem_rd <= 1'b0;
      o_mem    <= '0;
    end else begin
      o_mem_rd <= 1'b0;
      unique case (state)
        ST_RX: begin
          if (i_cmd_valid && i_cmd.last) begin
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state <= ST_SW1;
          rd_ne <= ne;
          if (hdr_n != 3'h4) begin
            sw <= SW_WRONG_LEN;
          end else if (hdr[0][CLA_CHAIN_BIT]) begin
            sw <= SW_NO_CHAIN;
          end else if (hdr[0] != CLA_PLAIN && hdr[0] != CLA_SECURE) begin
            sw <= SW_BAD_CLA;
          end else if (!len_ok) begin
            sw <= SW_WRONG_LEN;
          end else if (hdr[1] == INS_SELECT) begin
            if (hdr[3] != P2_NO_RSP_DATA) begin
              sw <= SW_BAD_P1P2;
            end else if (hdr[2] == P1_SEL_ROOT) begin
              if (hdr[0] != CLA_PLAIN) begin
                sw <= SW_BAD_CLA;
              end else if (has_lc || has_le) begin
                sw <= SW_WRONG_LEN;
              end else begin
                app_sel  <= 1'b0;
                ef_valid <= 1'b0;
                sw       <= SW_OK;
              end
            end else if (hdr[2] == P1_SEL_APP) begin
              if (hdr[0] != CLA_PLAIN) begin
                sw <= SW_BAD_CLA;
              end else if (!has_lc || has_le) begin
                sw <= SW_WRONG_LEN;
              end else if (aid_match) begin
                app_sel  <= 1'b1;
                ef_valid <= 1'b0;
                sw       <= SW_OK;
              end else begin
                sw <= SW_NOT_FOUND;
              end
            end else if (hdr[2] == P1_SEL_EF) begin
              if (!has_lc || has_le || lc != EF_ID_LEN) begin
                sw <= SW_WRONG_LEN;
              end else begin
                o_lookup <= '{by_sfi: 1'b0, sfi: '0,
                              fid: {body_at(ds),
                                    body_at(BODY_AW'(ds + 1'b1))}};
                act      <= ACT_SELECT;
                state    <= ST_LOOK;
              end
            end else begin
              sw <= SW_BAD_P1P2;
            end
          end else if (hdr[1] == INS_READ_EVEN) begin
            act <= ACT_READ;
            if (has_lc || !has_le) begin
              sw <= SW_WRONG_LEN;
            end else if (hdr[2][P1_SFI_FLAG_BIT]) begin
              if (hdr[2][6:5] != 2'b00) begin
                sw <= SW_BAD_P1P2;
              end else begin
                o_lookup <= '{by_sfi: 1'b1, sfi: hdr[2][4:0], fid: '0};
                rd_off   <= {16'h0000, hdr[3]};
                state    <= ST_LOOK;
              end
            end else if (!ef_valid) begin
              sw <= SW_NO_CUR_EF;
            end else begin
              o_lookup <= '{by_sfi: 1'b0, sfi: '0, fid: ef_fid};
              rd_off   <= {9'h000, hdr[2][6:0], hdr[3]};
              state    <= ST_LOOK;
            end
          end else if (hdr[1] == INS_READ_ODD) begin
            act <= ACT_READ;
            if (!has_lc || !has_le) begin
              sw <= SW_WRONG_LEN;
            end else if (!tlv_ok) begin
              sw <= SW_BAD_DATA;
            end else if ({hdr[2], hdr[3]} == 16'h0000) begin
              if (!ef_valid) begin
                sw <= SW_NO_CUR_EF;
              end else begin
                o_lookup <= '{by_sfi: 1'b0, sfi: '0, fid: ef_fid};
                rd_off   <= tlv_off;
                state    <= ST_LOOK;
              end
            end else if (hdr[2] == 8'h00 && hdr[3][7:5] == 3'b000) begin
              o_lookup <= '{by_sfi: 1'b1, sfi: hdr[3][4:0], fid: '0};
              rd_off   <= tlv_off;
              state    <= ST_LOOK;
            end else begin
              o_lookup <= '{by_sfi: 1'b0, sfi: '0, fid: {hdr[2], hdr[3]}};
              rd_off   <= tlv_off;
              state    <= ST_LOOK;
            end
          end else begin
            sw <= SW_BAD_INS;
          end
        end
        ST_LOOK: begin
          // Files inside the application stay hidden until it is named
          if (!i_lookup.hit || (i_lookup.in_app && !app_sel)) begin
            sw    <= SW_NOT_FOUND;
            state <= ST_SW1;
          end else begin
            ef_valid <= 1'b1;
            ef_fid   <= i_lookup.fid;
            ef_size  <= i_lookup.size;
            if (act == ACT_SELECT) begin
              sw    <= SW_OK;
              state <= ST_SW1;
            end else if (rd_off > i_lookup.size) begin
              sw    <= SW_BAD_OFFSET;
              state <= ST_SW1;
            end else begin
              rd_cnt <= min_ne(rd_ne, remain);
              o_mem  <= '{fid: i_lookup.fid, offset: rd_off};
              state  <= ST_READ;
            end
          end
        end
        ST_READ: begin
          if (rd_cnt == 17'h00000) begin
            sw    <= SW_OK;
            state <= ST_SW1;
          end else if (push_ready) begin
            o_mem_rd <= 1'b1;
            state    <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          // The FIFO fills only here and in ST_SW1/ST_SW2, so space seen in ST_READ holds
          o_mem.offset <= o_mem.offset + 1'b1;
          rd_cnt       <= rd_cnt - 1'b1;
          state        <= ST_READ;
        end
        ST_SW1: begin
          if (push_ready) begin
            state <= ST_SW2;
          end
        end
        ST_SW2: begin
          if (push_ready) begin
            state <= ST_RX;
          end
        end
      endcase
    end
  end

  // Response byte source
  always_comb begin
    push_valid = 1'b0;
    push_data  = '{last: 1'b0, data: 8'h00};
    unique case (state)
      ST_PUSH: begin
        push_valid = 1'b1;
        push_data  = '{last: 1'b0, data: i_mem_data};
      end
      ST_SW1: begin
        push_valid = 1'b1;
        push_data  = '{last: 1'b0, data: sw[15:8]};
      end
      ST_SW2: begin
        push_valid = 1'b1;
        push_data  = '{last: 1'b1, data: sw[7:0]};
      end
      default: begin
        push_valid = 1'b0;
      end
    endcase
  end

  afs_fifo #(
    .WIDTH ($bits(afs_byte_type)),
    .DEPTH (RSP_DEPTH)
  ) u_rsp_fifo (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (push_valid),
    .i_in_data   (push_data),
    .o_in_ready  (push_ready),
    .o_out_valid (o_rsp_valid),
    .o_out_data  (o_rsp),
    .i_out_ready (i_rsp_ready)
  );

endmodule : afs_top

`default_nettype wire
